/* nss_sequencer.sv */
// Slave bus cycle sequencer for a frame buffer card
`timescale 1ns/10ps
`include "nss_defines.svh"
module nss_sequencer #(
    parameter int DELAY_TAPS = `NSS_DELAY_CYC
) (
    input wire logic clk,                          // System clock, 10 MHz
    input wire logic sys_rst,                      // Async reset, active high
    input wire logic ce,                           // Clock enable
    input nss_pkg::nss_bus_in_t bus_in,            // Bus master pins
    input wire logic fb_ack_n,                     // Controller acknowledge
    input wire logic refresh_busy,                 // Controller refreshing
    input wire logic [`NSS_AD_W-1:0] fb_rdata,     // Frame buffer read data
    input wire logic [`NSS_BYTE_W-1:0] ctl_rdata,  // Control space read data
    input wire logic set_space_hit,                // Access to set space
    input wire logic clear_space_hit,              // Access to clear space
    input wire logic tv_pixel_clock,               // Television rate source
    input wire logic hires_pixel_clock,            // Monitor rate source
    input wire logic external_pixel_clock,         // External pixel clock
    input wire logic external_pixclk_select,       // External clock override
    input wire logic controller_pixclk_return,     // Controller's own copy
    output logic controller_pixel_clock_in,        // Pixel clock to controller
    output logic buffered_pixel_clock,             // Downstream pixel clock
    output logic controller_clk20,                 // Doubled bus clock
    output logic pas_n,                            // Address strobe
    output logic ram_req_n,                        // RAM-cycle request
    output logic mem_start,                        // Memory access starts
    output logic [`NSS_FB_ADDR_W-1:0] fb_addr,     // Address to controller
    output logic [`NSS_LATCH_W-1:0] addr_latch,    // ROM/palette address
    output logic ctl_cycle,                        // Latest cycle was a control cycle
    output logic buf_dir_read,                     // Data buffer toward bus
    output logic bus_ack_n,                        // Acknowledge to master
    output logic [`NSS_AD_W-1:0] bus_dout,         // Data to bus
    output logic bus_doe_n,                        // Data enable, low drives
    output logic clk_sel,                          // Pixel clock select bit
    output nss_pkg::nss_state_t cycle_state        // Current cycle state
);
    import nss_pkg::*;

    localparam int PW = $bits(nss_bus_in_t);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // Synchroniser stages and filtered levels
    logic [PW-1:0] sync1_reg;           // First stage, read only by stage 2
    logic [PW-1:0] sync2_reg;           // Second stage
    logic [PW-1:0] sync3_reg;           // Third stage
    logic [PW-1:0] pin_lvl_reg;         // Accepted level per pin
    nss_bus_in_t pin;                   // Accepted levels as a struct
    logic bus_clk_prev_reg;             // Bus clock level, one cycle ago
    logic tick;                         // Rising bus clock edge found

    // Cycle state and its three bits
    nss_state_t state_reg;              // Cycle state
    logic cycle_state_bit0;             // State bit zero
    logic cycle_state_bit1;             // State bit one
    logic cycle_state_bit2;             // State bit two
    logic [`NSS_ST_W-1:0] state_next;   // Next state bits
    logic slot_sel;                     // Slot selected, active high
    logic mid_window;                   // Timing window, active high
    logic fb_ack;                       // Controller acknowledge, high
    logic read_reg;                     // Transfer direction flag
    logic ctl_reg;                      // Latest cycle was a control cycle
    logic [`NSS_AD_W-1:0] swapped;      // Byte-reversed frame buffer data

    // Three-stage synchroniser per pin
    genvar i;
    generate
        for (i = 0; i < PW; i++)
        begin : g_sync
            always_ff @(posedge clk or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    sync1_reg[i] <= 1'b0;
                    sync2_reg[i] <= 1'b0;
                    sync3_reg[i] <= 1'b0;
                end
                else if (ce)
                begin
                    sync1_reg[i] <= bus_in[i];
                    sync2_reg[i] <= sync1_reg[i];
                    sync3_reg[i] <= sync2_reg[i];
                end
            end

            // A change counts once stages two and three agree
            always_ff @(posedge clk or posedge sys_rst)
            begin
                if (sys_rst)
                    pin_lvl_reg[i] <= 1'b0;
                else if (ce && (sync2_reg[i] == sync3_reg[i]))
                    pin_lvl_reg[i] <= sync3_reg[i];
            end
        end
    endgenerate

    assign pin = nss_bus_in_t'(pin_lvl_reg);

    // Edge finder on the accepted bus clock level
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            bus_clk_prev_reg <= 1'b0;
        else if (ce)
            bus_clk_prev_reg <= pin.bus_clk;
    end

    assign tick = ce && pin.bus_clk && !bus_clk_prev_reg;

    // Active-high views of the active-low select, window and acknowledge inputs
    assign slot_sel = !pin.slot_sel_n;
    assign mid_window = !pin.mid_window_n;
    assign fb_ack = !fb_ack_n;

    assign cycle_state_bit2 = state_reg[2];
    assign cycle_state_bit1 = state_reg[1];
    assign cycle_state_bit0 = state_reg[0];

    // Next state bits, each compared against numeric codes
    always_comb
    begin
        // Bit zero: set while bit one is clear, or waiting in state 3
        state_next[0] = !cycle_state_bit1 ||
            ((state_reg == ST_RAM_WAIT) && !fb_ack);
        // Bit one: RAM start, hold with bit zero, follow bit two
        state_next[1] = ((state_reg == ST_IDLE) && slot_sel &&
            !pin.space_select_addr_bit) ||
            (cycle_state_bit1 && cycle_state_bit0) ||
            (cycle_state_bit2 && !cycle_state_bit1);
        // Bit two: control start, hold only with bit zero
        state_next[2] = ((state_reg == ST_IDLE) && slot_sel &&
            pin.space_select_addr_bit) ||
            (cycle_state_bit2 && cycle_state_bit0);
    end

    // Cycle state register, forced to idle by reset
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            state_reg <= ST_IDLE;
        else if (tick)
            state_reg <= nss_state_t'(state_next);
    end

    // Transfer direction: set on select with mode bit one off
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            read_reg <= 1'b0;
        else if (tick)
            read_reg <= (slot_sel && pin.tm1_n) ||
                (read_reg && (state_reg != ST_DONE));
    end

    // Cycle kind: control when bit 19 is set at selection
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            ctl_reg <= 1'b0;
        else if (tick && (state_reg == ST_IDLE) && slot_sel)
            ctl_reg <= pin.space_select_addr_bit;
    end

    // Address latches loaded as the strobe falls, leaving idle
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            addr_latch <= '0;
            fb_addr <= '0;
        end
        else if (tick && (state_reg == ST_IDLE) && slot_sel)
        begin
            // Ten bits steer ROM and palette for the whole cycle
            addr_latch <= pin.ad[`NSS_LATCH_LSB +: `NSS_LATCH_W];
            // Controller copy of the address
            fb_addr <= pin.ad[`NSS_FB_ADDR_LSB +: `NSS_FB_ADDR_W];
        end
    end

    // Strobe: asserted in every state but idle, through acknowledge
    assign pas_n = (state_reg == ST_IDLE);

    // RAM request during state 3 inside the timing window
    assign ram_req_n = !((state_reg == ST_RAM_WAIT) && mid_window);

    // Memory start one clock after a bus clock edge, never without strobe
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            mem_start <= 1'b0;
        else if (ce)
            mem_start <= tick && !pas_n && !ram_req_n &&
                !refresh_busy;
    end

    // Bus acknowledge in the two acknowledge states
    assign bus_ack_n = !((state_reg == ST_RAM_ACK) ||
        (state_reg == ST_CTL_ACK));

    assign ctl_cycle = ctl_reg;
    assign buf_dir_read = read_reg;
    assign cycle_state = state_reg;

    // Frame buffer data has its byte order reversed for the bus
    always_comb
    begin
        swapped = {fb_rdata[7:0], fb_rdata[15:8],
            fb_rdata[23:16], fb_rdata[31:24]};
    end

    // Read data and drive enable toward the bus
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bus_dout <= `NSS_DOUT_RST;
            bus_doe_n <= 1'b1;
        end
        else if (ce)
        begin
            if (ctl_reg)
                // Control spaces use lane 0, upper lanes zero
                bus_dout <= {`NSS_LANE_HI_ZERO, ctl_rdata};
            else
                // Only frame buffer data is reordered
                bus_dout <= swapped;
            bus_doe_n <= !(read_reg && (state_next != `NSS_ST_IDLE) &&
                ((state_reg == ST_RAM_ACK) ||
                 (state_reg == ST_CTL_ACK)));
        end
    end

    // Pixel clock select bit, set and clear by space access
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            clk_sel <= `NSS_CLKSEL_RST;
        else if (ce && set_space_hit)
            clk_sel <= 1'b1;
        else if (ce && clear_space_hit)
            clk_sel <= 1'b0;
    end

    // Source multiplexer; the select changes on a set or clear space access while ce is high
    assign controller_pixel_clock_in = external_pixclk_select ?
        external_pixel_clock :
        (clk_sel ? tv_pixel_clock : hires_pixel_clock);

    // Controller's returned copy clocks the pixel circuitry
    assign buffered_pixel_clock = controller_pixclk_return;

    // Doubled clock for the controller
    nss_clock_doubler #(
        .TAPS(DELAY_TAPS)
    ) u_doubler (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .bus_clk_lvl(pin.bus_clk),
        .clk_double(controller_clk20)
    );

    // Idle with select and bit 19 low starts a RAM cycle
    a_idle_to_ram: assert property (
        (tick && (state_reg == ST_IDLE) && slot_sel &&
         !pin.space_select_addr_bit) |=> (state_reg == ST_RAM_WAIT))
        else $error("idle did not enter RAM wait");

    // Idle with select and bit 19 high starts a control cycle
    a_idle_to_ctl: assert property (
        (tick && (state_reg == ST_IDLE) && slot_sel &&
         pin.space_select_addr_bit) |=> (state_reg == ST_CTL_A))
        else $error("idle did not enter control cycle");

    // RAM wait holds while the controller has not acknowledged
    a_wait_holds: assert property (
        (tick && (state_reg == ST_RAM_WAIT) && !fb_ack)
        |=> (state_reg == ST_RAM_WAIT))
        else $error("RAM wait left without acknowledge");

    // Control cycle steps from state 5 to state 7 on the next tick
    a_ctl_walk: assert property (
        (tick && (state_reg == ST_CTL_A)) |=> (state_reg == ST_CTL_B))
        else $error("control cycle did not reach state 7");

    // After RAM acknowledge the machine is done, then idle again within 40 clocks
    a_ack_to_idle: assert property (
        (tick && (state_reg == ST_RAM_ACK)) |=> (state_reg == ST_DONE)
        ##[1:40] (state_reg == ST_IDLE))
        else $error("no return to idle after acknowledge");

    // Strobe rises only out of state 0, after the acknowledge
    a_strobe_hold: assert property (
        $rose(pas_n) |-> $past(state_reg == ST_DONE))
        else $error("strobe rose before acknowledge");

    // Memory start only follows strobe, request and no refresh
    a_start_gate: assert property (
        mem_start |-> $past(!pas_n && !ram_req_n && !refresh_busy))
        else $error("memory start without strobe and request");

    // A request seen at a bus clock starts an access next clock
    a_req_window: assert property (
        (tick && !ram_req_n && !refresh_busy) |=> mem_start)
        else $error("RAM request did not start an access");

    // Address latch takes the bus bits as the cycle opens
    a_addr_latch: assert property (
        (tick && (state_reg == ST_IDLE) && slot_sel) |=>
        (addr_latch == $past(pin.ad[`NSS_LATCH_LSB +: `NSS_LATCH_W])))
        else $error("address latch missed the bus address");

    // Control reads carry data on lane 0 only
    a_lane_zero: assert property (
        (!bus_doe_n && ctl_reg && $stable(ctl_reg)) |->
        (bus_dout[31:8] == '0))
        else $error("control data outside lane 0");

    // Set space access selects the television rate source
    a_clksel_set: assert property (
        (ce && set_space_hit) |=> clk_sel)
        else $error("set space did not select source");

endmodule : nss_sequencer

/* nss_defines.svh */
// Constants for the slave cycle sequencer: state codes, fields, timing
`ifndef NSS_DEFINES_SVH
`define NSS_DEFINES_SVH

// Cycle state width and numeric state codes (bit2, bit1, bit0)
`define NSS_ST_W 3
`define NSS_ST_DONE 3'h0
`define NSS_ST_IDLE 3'h1
`define NSS_ST_RAM_ACK 3'h2
`define NSS_ST_RAM_WAIT 3'h3
`define NSS_ST_CTL_A 3'h5
`define NSS_ST_CTL_ACK 3'h6
`define NSS_ST_CTL_B 3'h7

// Bus address/data field layout
`define NSS_AD_W 32
`define NSS_BYTE_W 8
`define NSS_LATCH_W 10
`define NSS_LATCH_LSB 2
`define NSS_FB_ADDR_W 22
`define NSS_FB_ADDR_LSB 2
`define NSS_LANE_HI_ZERO 24'h00_0000
`define NSS_DOUT_RST 32'h0000_0000

// Reset values
`define NSS_CLKSEL_RST 1'b0

// Pin synchroniser depth
`define NSS_SYNC_STAGES 3

// Delay line and clock timing in ns, and the delay in clocks
`define NSS_DELAY_NS 100
`define NSS_CLK_NS 100
`define NSS_DELAY_CYC (((`NSS_DELAY_NS) / (`NSS_CLK_NS)) < 1 ? 1 : \
    ((`NSS_DELAY_NS) / (`NSS_CLK_NS)))

`endif

/* nss_pkg.sv */
// Types shared by the slave cycle sequencer files
package nss_pkg;

`include "nss_defines.svh"

    // Cycle state, values are the numeric state codes
    typedef enum logic [`NSS_ST_W-1:0]
    {
        ST_DONE = `NSS_ST_DONE,
        ST_IDLE = `NSS_ST_IDLE,
        ST_RAM_WAIT = `NSS_ST_RAM_WAIT,
        ST_RAM_ACK = `NSS_ST_RAM_ACK,
        ST_CTL_A = `NSS_ST_CTL_A,
        ST_CTL_B = `NSS_ST_CTL_B,
        ST_CTL_ACK = `NSS_ST_CTL_ACK
    } nss_state_t;

    // Pins arriving from the bus master's side, asynchronous to clk
    typedef struct packed
    {
        logic bus_clk;                    // Bus clock level
        logic [`NSS_AD_W-1:0] ad;         // Multiplexed address/data
        logic slot_sel_n;                 // Decoded slot select
        logic space_select_addr_bit;      // Address bit 19
        logic tm1_n;                      // Transfer-mode bit one
        logic mid_window_n;               // Mid-cycle timing window
    } nss_bus_in_t;

endpackage : nss_pkg

/* nss_clock_doubler.sv */
// Tapped delay line that doubles the sampled bus clock rate
`timescale 1ns/10ps
`include "nss_defines.svh"
module nss_clock_doubler #(
    parameter int TAPS = `NSS_DELAY_CYC
) (
    input wire logic clk,          // System clock
    input wire logic sys_rst,      // Asynchronous reset, active high
    input wire logic ce,           // Clock enable
    input wire logic bus_clk_lvl,  // Filtered bus clock level
    output logic clk_double        // Doubled-rate clock
);
    import nss_pkg::*;

    logic [TAPS:0] tap_reg;        // Delay line taps, tap 0 is the input

    assign tap_reg[0] = bus_clk_lvl;

    // One flip-flop per tap of the delay line after tap 0
    genvar i;
    generate
        for (i = 1; i <= TAPS; i++)
        begin : g_tap
            always_ff @(posedge clk or posedge sys_rst)
            begin
                if (sys_rst)
                    tap_reg[i] <= 1'b0;
                else if (ce)
                    tap_reg[i] <= tap_reg[i-1];
            end
        end
    endgenerate

    // First and last taps combine: a pulse follows every bus clock edge
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            clk_double <= 1'b0;
        else if (ce)
            clk_double <= tap_reg[0] ^ tap_reg[TAPS];
    end

endmodule : nss_clock_doubler

/* nss_bus_master.sv */
// Bus master model: free-running bus clock, window, slot cycles
`timescale 1ns/10ps
module nss_bus_master
    import nss_pkg::*;
(
    output nss_pkg::nss_bus_in_t bus_in  // Pins toward the sequencer
);
    // Bus clock of 800 ns, high one quarter, window spans each rise after the first
    initial
    begin
        bus_in = '0;
        bus_in.ad = 32'hFFFF_FFFF;
        bus_in.slot_sel_n = 1'h1;
        bus_in.tm1_n = 1'h1;
        bus_in.mid_window_n = 1'h1;
        #37;
        forever
        begin
            bus_in.bus_clk = 1'h1;
            #200;
            bus_in.bus_clk = 1'h0;
            #100;
            bus_in.mid_window_n = 1'h1;  // Window closes after the rise
            #300;
            bus_in.mid_window_n = 1'h0;  // Window opens before the rise
            #200;
        end
    end

    // Present one slot cycle across one bus clock rise, then release
    task automatic present(
        input logic b19,         // Control space when high
        input logic tm1_n,       // High for a read
        input logic [31:0] addr  // Address phase value
    );
        @(negedge bus_in.bus_clk);
        bus_in.slot_sel_n = 1'h0;
        bus_in.space_select_addr_bit = b19;
        bus_in.tm1_n = tm1_n;
        bus_in.ad = addr;
        @(negedge bus_in.bus_clk);
        bus_in.slot_sel_n = 1'h1;
        bus_in.tm1_n = 1'h1;
        bus_in.ad = ~addr;  // Released lines keep no stale address
    endtask : present
endmodule : nss_bus_master

/* tb_nss_sequencer.sv */
// Self-checking bench for the slave cycle sequencer
`timescale 1ns/10ps
module tb_nss_sequencer;
    import nss_pkg::*;
    logic clk = 1'h0;             // System clock
    logic sys_rst = 1'h1;         // Reset, active high
    logic ce = 1'h1;              // Clock enable
    nss_bus_in_t bus_in;          // Pins from the master model
    logic fb_ack_n = 1'h1;        // Controller acknowledge
    logic refresh_busy = 1'h0;    // Controller refreshing
    logic [31:0] fb_rdata = 32'h0000_0000;  // Frame buffer data
    logic [7:0] ctl_rdata = 8'h00;          // Control space data
    logic set_hit = 1'h0;         // Set space access
    logic clr_hit = 1'h0;         // Clear space access
    logic tv = 1'h0;              // Television rate source
    logic hires = 1'h0;           // Monitor rate source
    logic ext = 1'h0;             // External pixel clock
    logic ext_sel = 1'h0;         // External override
    logic ret = 1'h0;             // Controller's returned clock
    logic pix_in, pix_buf, clk20, pas_n, ram_req_n, mem_start;
    logic [21:0] fb_addr;
    logic [9:0] addr_latch;
    logic ctl_cycle, buf_dir_read, bus_ack_n, bus_doe_n, clk_sel;
    logic [31:0] bus_dout;
    nss_state_t cycle_state;
    int fail_count = 0;
    int total_checks = 0;
    int ms_cnt = 0;               // Memory start pulses seen

    // Clock, 100 ns period
    always #50 clk = ~clk;

    // Count memory start pulses
    always @(posedge clk)
    begin
        if (mem_start === 1'h1)
            ms_cnt <= ms_cnt + 1;
    end

    nss_bus_master master_u (.bus_in(bus_in));

    nss_sequencer dut_u (
        .clk(clk), .sys_rst(sys_rst), .ce(ce), .bus_in(bus_in),
        .fb_ack_n(fb_ack_n), .refresh_busy(refresh_busy),
        .fb_rdata(fb_rdata), .ctl_rdata(ctl_rdata),
        .set_space_hit(set_hit), .clear_space_hit(clr_hit),
        .tv_pixel_clock(tv), .hires_pixel_clock(hires),
        .external_pixel_clock(ext), .external_pixclk_select(ext_sel),
        .controller_pixclk_return(ret),
        .controller_pixel_clock_in(pix_in),
        .buffered_pixel_clock(pix_buf), .controller_clk20(clk20),
        .pas_n(pas_n), .ram_req_n(ram_req_n), .mem_start(mem_start),
        .fb_addr(fb_addr), .addr_latch(addr_latch),
        .ctl_cycle(ctl_cycle), .buf_dir_read(buf_dir_read),
        .bus_ack_n(bus_ack_n), .bus_dout(bus_dout),
        .bus_doe_n(bus_doe_n), .clk_sel(clk_sel),
        .cycle_state(cycle_state)
    );

    // Print counts and verdict, then stop
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    // Watchdog against a hung handshake
    initial
    begin
        #300_000;
        fail_count++;
        conclude();
    end

    // Advance n clocks, landing just after the edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step

    // Compare one bit
    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1

    // Compare a vector
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk32

    // Wait a bounded time for a state code, then compare it
    task automatic wait_state(input nss_state_t s);
        int n;
        n = 0;
        while (cycle_state !== s && n < 40)
        begin
            step(1);
            n++;
        end
        chk32({29'h0, cycle_state}, {29'h0, s});
    endtask : wait_state

    // Values held in reset
    task automatic t_reset();
        chk32({29'h0, cycle_state}, {29'h0, ST_IDLE});
        chk1(pas_n, 1'h1);
        chk1(ram_req_n, 1'h1);
        chk1(bus_ack_n, 1'h1);
        chk1(mem_start, 1'h0);
        chk1(clk_sel, 1'h0);
        $display("reset test done");
    endtask : t_reset

    // One frame buffer cycle with a slow acknowledge
    task automatic ram_cycle(input logic rd, input logic rfsh,
        input logic [31:0] a, input logic [31:0] d);
        int ms0;
        int n;
        ms0 = ms_cnt;
        refresh_busy = rfsh;
        fb_rdata = d;
        master_u.present(1'h0, rd, a);
        wait_state(ST_RAM_WAIT);
        chk1(pas_n, 1'h0);
        chk1(ctl_cycle, 1'h0);
        chk32({22'h0, addr_latch}, {22'h0, a[11:2]});
        chk32({10'h000, fb_addr}, {10'h000, a[23:2]});
        chk1(buf_dir_read, rd);
        n = 0;
        while (ram_req_n !== 1'h0 && n < 20)
        begin
            step(1);
            n++;
        end
        chk1(ram_req_n, 1'h0);
        step(16);
        chk32({29'h0, cycle_state}, {29'h0, ST_RAM_WAIT});
        chk1(ms_cnt > ms0, !rfsh);
        fb_ack_n = 1'h0;
        wait_state(ST_RAM_ACK);
        chk1(bus_ack_n, 1'h0);
        chk1(pas_n, 1'h0);
        fb_ack_n = 1'h1;
        step(2);
        chk1(bus_doe_n, !rd);
        chk32(bus_dout, {d[7:0], d[15:8], d[23:16], d[31:24]});
        wait_state(ST_DONE);
        chk1(pas_n, 1'h0);
        wait_state(ST_IDLE);
        chk1(pas_n, 1'h1);
        chk1(buf_dir_read, 1'h0);
        refresh_busy = 1'h0;
        $display("ram cycle test done");
    endtask : ram_cycle

    // One control space cycle through states 5, 7, 6
    task automatic ctl_run(input logic rd, input logic [31:0] a,
        input logic [7:0] cd);
        ctl_rdata = cd;
        master_u.present(1'h1, rd, a);
        wait_state(ST_CTL_A);
        chk1(ctl_cycle, 1'h1);
        chk1(ram_req_n, 1'h1);
        wait_state(ST_CTL_B);
        wait_state(ST_CTL_ACK);
        chk1(bus_ack_n, 1'h0);
        chk1(pas_n, 1'h0);
        step(2);
        chk32(bus_dout, {24'h00_0000, cd});
        chk1(bus_doe_n, !rd);
        wait_state(ST_DONE);
        wait_state(ST_IDLE);
        $display("control cycle test done");
    endtask : ctl_run

    // Doubled clock: two pulses per bus clock period
    task automatic t_doubler();
        int n;
        logic prev;
        n = 0;
        prev = clk20;
        repeat (64)
        begin
            step(1);
            if (clk20 === 1'h1 && prev === 1'h0)
                n++;
            prev = clk20;
        end
        chk32(n, 32'h0000_0010);
        $display("doubler test done");
    endtask : t_doubler

    // Pixel clock selection, changed with no bus cycle running
    task automatic t_clksel();
        tv = 1'h1;
        set_hit = 1'h1;
        step(1);
        set_hit = 1'h0;
        chk1(clk_sel, 1'h1);
        chk1(pix_in, 1'h1);
        clr_hit = 1'h1;
        step(1);
        clr_hit = 1'h0;
        chk1(clk_sel, 1'h0);
        chk1(pix_in, 1'h0);
        set_hit = 1'h1;
        clr_hit = 1'h1;
        step(1);
        set_hit = 1'h0;
        clr_hit = 1'h0;
        chk1(clk_sel, 1'h1);
        ce = 1'h0;
        clr_hit = 1'h1;
        step(2);
        clr_hit = 1'h0;
        chk1(clk_sel, 1'h1);
        ce = 1'h1;
        ext_sel = 1'h1;
        ext = 1'h0;
        ret = 1'h1;
        #1;
        chk1(pix_in, 1'h0);
        chk1(pix_buf, 1'h1);
        ret = 1'h0;
        #1;
        chk1(pix_buf, 1'h0);
        $display("clock select test done");
    endtask : t_clksel

    // Main sequence
    initial
    begin
        step(15);
        t_reset();
        step(1);
        sys_rst = 1'h0;
        step(8);
        ram_cycle(1'h1, 1'h0, 32'h00A5_5A5C, 32'h1122_3344);
        ram_cycle(1'h0, 1'h1, 32'h0012_3FFC, 32'h0000_0000);
        ctl_run(1'h1, 32'h00F0_0004, 8'hA7);
        ctl_run(1'h0, 32'h0080_03F0, 8'h5C);
        ram_cycle(1'h1, 1'h0, 32'h003F_FFFC, 32'hDEAD_BEEF);
        t_doubler();
        t_clksel();
        conclude();
    end
endmodule : tb_nss_sequencer
